// [src/tms_mode_sequencer.sv]
// Purpose: Operating mode state machine and power enables of a transmitter.
// Assumes: chip_sel and sck come from pins; config writes are on ref_clk.
// Notes:   Overview of operation is listed below.
//
// Overview of operation
// - Five states: sleep, standby, transmit, oscillator and synth warm-up.
// - Sleep wakes on chip-select high plus three SCK pulses.
// - Sleep request bit set, then chip-select falling, enters sleep.
// - Sleep request bit clears itself on wake from sleep.
// - Sleep takes effect two system clocks after the committing edge.
// - Chip-select low without SCK for 65536 clocks enters standby.
// - Retention request bit set, sleep request clear, then chip-select falling, enters standby.
// - Standby keeps serial, bank and system controller powered.
// - Standby keeps checking register parity against stored bits.
// - A transmit command leads into transmit with PLL and amplifier on.
// - Hold clear leaves transmit on chip-select fall, else after timeout.
// - Transmit enables regulator, reset, detector, oscillator, PLL, amp.
// - Chip-select rise in standby enters oscillator warm-up.
// - Warm-up ends on sleep, retention, transmit command or idle timeout.
// - Synth warm-up runs the PLL with the amplifier still off.
// - Sleep powers only low-power regulator, serial, reset, detector.
// - Retention request bit clears itself once acted upon.
`timescale 1ns/1ps
module tms_mode_sequencer #(
  parameter int unsigned IDLE_TIMEOUT = tms_pkg::IDLE_TIMEOUT_CYCLES,
  parameter int unsigned NUM_REGS     = tms_pkg::NUM_CFG_REGS
)(
  input  wire logic                               ref_clk,
  input  wire logic                               rst,
  input  wire logic                               chip_sel,
  input  wire logic                               sck,
  input  wire logic                               cfg_wr_en,
  input  wire logic [tms_pkg::CFG_ADDR_W-1:0]     cfg_wr_addr,
  input  wire logic [tms_pkg::CFG_W-1:0]          cfg_wr_data,
  input  wire logic [NUM_REGS*tms_pkg::CFG_W-1:0] cfg_bank,
  input  wire logic                               tx_cmd,
  input  wire logic                               tx_hold,
  input  wire logic                               parity_error_clr,
  output tms_pkg::tms_state_t                     mode_state,
  output logic                                    sleep_request,
  output logic                                    retention_request,
  output logic                                    parity_error,
  output logic                                    lp_regulator_en,
  output logic                                    normal_regulator_en,
  output logic                                    por_en,
  output logic                                    undervoltage_full_en,
  output logic                                    undervoltage_low_en,
  output logic                                    crystal_oscillator_en,
  output logic                                    clock_divider_en,
  output logic                                    pll_en,
  output logic                                    power_amplifier_en,
  output logic                                    serial_if_en,
  output logic                                    core_supply_en,
  output logic                                    sys_ctrl_en
);
  import tms_pkg::*;

  localparam int unsigned CNT_W = $clog2(IDLE_TIMEOUT + 1);
  localparam int unsigned SH_W  = $clog2(SHUTDOWN_CYCLES + 1);
  localparam int unsigned WK_W  = $clog2(WAKE_SCK_PULSES + 1);
  localparam int unsigned SET_W = $clog2(SYNTH_SETTLE_CYCLES + 1);
  localparam logic [CNT_W-1:0] IDLE_LAST   = CNT_W'(IDLE_TIMEOUT - 1);
  localparam logic [SH_W-1:0]  SHUT_LAST   = SH_W'(SHUTDOWN_CYCLES);
  localparam logic [WK_W-1:0]  WAKE_LAST   = WK_W'(WAKE_SCK_PULSES - 1);
  localparam logic [SET_W-1:0] SETTLE_LAST = SET_W'(SYNTH_SETTLE_CYCLES - 1);

  tms_state_t        st_r;
  tms_state_t        st_nxt;
  logic [1:0]        pins_s;
  logic              cs_d_r;
  logic              sck_d_r;
  logic [CNT_W-1:0]  idle_cnt_r;
  logic [SH_W-1:0]   shut_cnt_r;
  logic [WK_W-1:0]   wake_cnt_r;
  logic [SET_W-1:0]  settle_cnt_r;
  logic              hold_r;
  logic              sleep_request_r;
  logic              retention_request_r;
  logic              parity_error_r;
  logic [NUM_REGS-1:0] parity_r;
  logic [NUM_REGS-1:0] mismatch;
  logic [PWR_N-1:0]  pwr_r;
  logic [PWR_N-1:0]  pwr_nxt;

  tms_sync #(
    .WIDTH    (2)
  ) u_sync (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in ({sck, chip_sel}),
    .sync_out (pins_s)
  );

  // Pin events, seen only after the synchroniser.
  wire cs_s      = pins_s[0];
  wire sck_s     = pins_s[1];
  wire cs_rise   = cs_s & ~cs_d_r;
  wire cs_fall   = ~cs_s & cs_d_r;
  wire sck_rise  = sck_s & ~sck_d_r;

  wire in_sleep  = (st_r == TMS_SLEEP);
  wire in_warm   = (st_r == TMS_OSC_WARMUP);
  wire shut_busy = (shut_cnt_r != '0);
  wire shut_done = (shut_cnt_r == SHUT_LAST);
  wire idle      = ~cs_s & ~sck_rise;
  wire idle_hit  = idle & (idle_cnt_r == IDLE_LAST);

  // The bank is unpowered in sleep, so writes there are dropped.
  wire cfg_wr_ok = cfg_wr_en & ~in_sleep;
  wire cfg0_req  = cfg_wr_ok & (cfg_wr_addr == TRANSMITTER_CONFIG_0_ADDR)
                   & cfg_wr_data[REQUEST_BIT];
  wire cfg1_req  = cfg_wr_ok & (cfg_wr_addr == TRANSMITTER_CONFIG_1_ADDR)
                   & cfg_wr_data[REQUEST_BIT];

  wire commit_sleep = in_warm & cs_fall & sleep_request_r & ~shut_busy;
  wire commit_ret   = in_warm & cs_fall & retention_request_r
                      & ~sleep_request_r & ~shut_busy;
  // A sleep commit in the same cycle wins over a transmit command.
  wire tx_start     = in_warm & tx_cmd & ~shut_busy & ~commit_sleep;
  wire wake         = in_sleep & cs_s & sck_rise
                      & (wake_cnt_r == WAKE_LAST);
  wire settle_done  = (settle_cnt_r == SETTLE_LAST);

  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      TMS_SLEEP:
        if (wake)
          st_nxt = TMS_OSC_WARMUP;
      TMS_STANDBY:
        if (cs_rise)
          st_nxt = TMS_OSC_WARMUP;
      TMS_OSC_WARMUP:
        if (shut_done)
          st_nxt = TMS_SLEEP;
        else if (commit_ret)
          st_nxt = TMS_STANDBY;
        else if (tx_start)
          st_nxt = TMS_SYNTH_WARMUP;
        else if (idle_hit && !shut_busy && !commit_sleep)
          st_nxt = TMS_STANDBY;
      TMS_SYNTH_WARMUP:
        if (settle_done)
          st_nxt = TMS_TRANSMIT;
      TMS_TRANSMIT:
        if (hold_r ? idle_hit : cs_fall)
          st_nxt = TMS_OSC_WARMUP;
      default:
        st_nxt = TMS_OSC_WARMUP;
    endcase
  end

  assign pwr_nxt = tms_pwr_decode(st_nxt);

  // The state machine starts in warm-up, as after power up.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      st_r  <= TMS_OSC_WARMUP;
      pwr_r <= PWR_WARMUP;
    end
    else
    begin
      st_r  <= st_nxt;
      pwr_r <= pwr_nxt;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      cs_d_r  <= 1'b0;
      sck_d_r <= 1'b0;
    end
    else
    begin
      cs_d_r  <= cs_s;
      sck_d_r <= sck_s;
    end
  end

  // Idle time: chip-select low and no rising SCK edge, restarted on state change.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      idle_cnt_r <= '0;
    else if (st_nxt != st_r || !idle)
      idle_cnt_r <= '0;
    else if (!idle_hit)
      idle_cnt_r <= idle_cnt_r + CNT_W'(1);
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      shut_cnt_r <= '0;
    else if (commit_sleep)
      shut_cnt_r <= SH_W'(1);
    else if (shut_done)
      shut_cnt_r <= '0;
    else if (shut_busy)
      shut_cnt_r <= shut_cnt_r + SH_W'(1);
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      wake_cnt_r <= '0;
    else if (!in_sleep || !cs_s)
      wake_cnt_r <= '0;
    else if (sck_rise)
      wake_cnt_r <= wake_cnt_r + WK_W'(1);
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      settle_cnt_r <= '0;
    else if (st_r != TMS_SYNTH_WARMUP)
      settle_cnt_r <= '0;
    else
      settle_cnt_r <= settle_cnt_r + SET_W'(1);
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      hold_r <= 1'b0;
    else if (tx_start)
      hold_r <= tx_hold;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      sleep_request_r     <= 1'b0;
      retention_request_r <= 1'b0;
    end
    else
    begin
      if (wake)
        sleep_request_r <= 1'b0;
      else if (cfg1_req)
        sleep_request_r <= 1'b1;
      if (cfg0_req)
        retention_request_r <= 1'b1;
      else if (commit_ret)
        retention_request_r <= 1'b0;
    end
  end

  // One parity bit per register, written with the register.
  for (genvar i = 0; i < NUM_REGS; i++) begin : g_par
    assign mismatch[i] = (^cfg_bank[i*CFG_W +: CFG_W]) != parity_r[i];
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      parity_r <= '0;
    else if (in_sleep)
      parity_r <= '0;
    else if (cfg_wr_ok)
      parity_r[cfg_wr_addr] <= ^cfg_wr_data;
  end

  // Sticky flag; a new mismatch wins over a clear in the same cycle.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      parity_error_r <= 1'b0;
    else if (!in_sleep && |mismatch)
      parity_error_r <= 1'b1;
    else if (in_sleep || parity_error_clr)
      parity_error_r <= 1'b0;
  end

  assign mode_state            = st_r;
  assign sleep_request         = sleep_request_r;
  assign retention_request     = retention_request_r;
  assign parity_error          = parity_error_r;
  assign lp_regulator_en       = pwr_r[PWR_LP_REG];
  assign normal_regulator_en   = pwr_r[PWR_NORM_REG];
  assign por_en                = pwr_r[PWR_POR];
  assign undervoltage_full_en  = pwr_r[PWR_UV_FULL];
  assign undervoltage_low_en   = pwr_r[PWR_UV_LOW];
  assign crystal_oscillator_en = pwr_r[PWR_CRYSTAL_OSCILLATOR];
  assign clock_divider_en      = pwr_r[PWR_CLKDIV];
  assign pll_en                = pwr_r[PWR_PLL];
  assign power_amplifier_en    = pwr_r[PWR_PA];
  assign serial_if_en          = pwr_r[PWR_SERIAL];
  assign core_supply_en        = pwr_r[PWR_CORE];
  assign sys_ctrl_en           = pwr_r[PWR_SYSCTL];

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  property p_sleep_latency;
    commit_sleep |=> (st_r == TMS_OSC_WARMUP) [*2] ##1 (st_r == TMS_SLEEP);
  endproperty
  a_sleep_latency: assert property (p_sleep_latency)
    else $error("Sleep not entered two cycles after commit.");

  property p_sleep_hold;
    (in_sleep && !cs_s) |=> (st_r == TMS_SLEEP);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold)
    else $error("Left sleep with chip-select low.");

  property p_wake_clears;
    in_sleep ##1 (st_r != TMS_SLEEP) |-> !sleep_request_r
      && (st_r == TMS_OSC_WARMUP) && $past(cs_s);
  endproperty
  a_wake_clears: assert property (p_wake_clears)
    else $error("Wake left the sleep request set.");

  property p_idle_standby;
    (in_warm && idle_hit && !shut_busy && !cs_fall && !tx_cmd)
      |=> (st_r == TMS_STANDBY);
  endproperty
  a_idle_standby: assert property (p_idle_standby)
    else $error("Idle timeout did not enter standby.");

  property p_tx_leave;
    (st_r == TMS_TRANSMIT && !hold_r && cs_fall) |=> in_warm;
  endproperty
  a_tx_leave: assert property (p_tx_leave)
    else $error("Transmit not left on chip-select fall.");

  property p_pa_after_pll;
    $rose(power_amplifier_en) |-> $past(pll_en) && !$past(power_amplifier_en)
      && (st_r == TMS_TRANSMIT);
  endproperty
  a_pa_after_pll: assert property (p_pa_after_pll)
    else $error("Amplifier on without prior synth warm-up.");

  property p_tx_power;
    (st_r == TMS_TRANSMIT) |-> normal_regulator_en && por_en
      && undervoltage_full_en && crystal_oscillator_en && pll_en
      && power_amplifier_en;
  endproperty
  a_tx_power: assert property (p_tx_power)
    else $error("Transmit power set incomplete.");

  property p_sleep_power;
    in_sleep |-> lp_regulator_en && serial_if_en && por_en
      && undervoltage_low_en && !core_supply_en && !crystal_oscillator_en;
  endproperty
  a_sleep_power: assert property (p_sleep_power)
    else $error("Sleep power set wrong.");

  property p_standby_power;
    (st_r == TMS_STANDBY) |-> core_supply_en && sys_ctrl_en && serial_if_en
      && !normal_regulator_en && !crystal_oscillator_en;
  endproperty
  a_standby_power: assert property (p_standby_power)
    else $error("Standby power set wrong.");

  property p_standby_wake;
    (st_r == TMS_STANDBY && cs_rise) |=> in_warm;
  endproperty
  a_standby_wake: assert property (p_standby_wake)
    else $error("Chip-select rise did not leave standby.");

  property p_tx_start;
    tx_start |=> (st_r == TMS_SYNTH_WARMUP) [*8];
  endproperty
  a_tx_start: assert property (p_tx_start)
    else $error("Transmit command did not start synth warm-up.");

  property p_ret_commit;
    commit_ret |=> (st_r == TMS_STANDBY) && !retention_request_r;
  endproperty
  a_ret_commit: assert property (p_ret_commit)
    else $error("Retention request not acted upon and cleared.");

  property p_parity;
    (!in_sleep && |mismatch) |=> parity_error_r;
  endproperty
  a_parity: assert property (p_parity)
    else $error("Parity mismatch not flagged.");

  property p_enable_on_step;
    !$stable(pwr_r) |-> !$stable(st_r);
  endproperty
  a_enable_on_step: assert property (p_enable_on_step)
    else $error("Enable changed without a state change.");

  c_wake: cover property (in_sleep ##1 in_warm);
  c_hold_tx: cover property ((st_r == TMS_TRANSMIT && hold_r) ##1 in_warm);
  c_idle_sb: cover property (in_warm && idle_hit ##1 st_r == TMS_STANDBY);
  c_par_err: cover property ($rose(parity_error_r));

endmodule : tms_mode_sequencer

// [src/tms_pkg.sv]
// Purpose: Shared constants and types of the transmitter mode sequencer.
// Assumes: The system clock of the sequencer is ref_clk at 20 MHz.
// Notes:   Power patterns hold one enable bit per controlled block.
package tms_pkg;

  localparam longint unsigned REF_CLK_HZ                = 20000000;
  localparam longint unsigned SYSTEM_CLOCK_FREQUENCY_HZ = 20000000;

  // Times counted in periods of the system clock.
  localparam longint unsigned IDLE_TIMEOUT_PERIODS    = 65536;
  localparam longint unsigned SHUTDOWN_PERIODS        = 2;
  localparam int unsigned     IDLE_TIMEOUT_CYCLES     = int'(
    (IDLE_TIMEOUT_PERIODS * REF_CLK_HZ) / SYSTEM_CLOCK_FREQUENCY_HZ);
  localparam int unsigned     SHUTDOWN_CYCLES         = int'(
    (SHUTDOWN_PERIODS * REF_CLK_HZ) / SYSTEM_CLOCK_FREQUENCY_HZ);
  localparam int unsigned     WAKE_SCK_PULSES         = 3;
  localparam int unsigned     SYNTH_SETTLE_CYCLES     = 16;

  // Configuration register bank.
  localparam int unsigned     NUM_CFG_REGS            = 32;
  localparam int unsigned     CFG_W                   = 8;
  localparam int unsigned     CFG_ADDR_W              = 5;
  localparam logic [4:0]      TRANSMITTER_CONFIG_0_ADDR = 5'h04;
  localparam logic [4:0]      TRANSMITTER_CONFIG_1_ADDR = 5'h05;
  localparam int unsigned     REQUEST_BIT             = 7;

  // Power enable bit positions.
  localparam int unsigned PWR_N         = 12;
  localparam int unsigned PWR_LP_REG    = 0;
  localparam int unsigned PWR_NORM_REG  = 1;
  localparam int unsigned PWR_POR       = 2;
  localparam int unsigned PWR_UV_FULL   = 3;
  localparam int unsigned PWR_UV_LOW    = 4;
  localparam int unsigned PWR_CRYSTAL_OSCILLATOR      = 5;
  localparam int unsigned PWR_CLKDIV    = 6;
  localparam int unsigned PWR_PLL       = 7;
  localparam int unsigned PWR_PA        = 8;
  localparam int unsigned PWR_SERIAL    = 9;
  localparam int unsigned PWR_CORE      = 10;
  localparam int unsigned PWR_SYSCTL    = 11;

  // Power patterns per state.
  localparam logic [11:0] PWR_SLEEP     = 12'h215;
  localparam logic [11:0] PWR_STANDBY   = 12'he15;
  localparam logic [11:0] PWR_WARMUP    = 12'he6e;
  localparam logic [11:0] PWR_SYNTH     = 12'heae;
  localparam logic [11:0] PWR_TRANSMIT  = 12'hfae;

  typedef enum logic [2:0] {
    TMS_SLEEP,
    TMS_STANDBY,
    TMS_OSC_WARMUP,
    TMS_SYNTH_WARMUP,
    TMS_TRANSMIT
  } tms_state_t;

  function automatic logic [11:0] tms_pwr_decode(input tms_state_t st);
    logic [11:0] p;
    p = PWR_WARMUP;
    case (st)
      TMS_SLEEP:        p = PWR_SLEEP;
      TMS_STANDBY:      p = PWR_STANDBY;
      TMS_SYNTH_WARMUP: p = PWR_SYNTH;
      TMS_TRANSMIT:     p = PWR_TRANSMIT;
      default:          p = PWR_WARMUP;
    endcase
    return p;
  endfunction : tms_pwr_decode

endpackage : tms_pkg

// [src/tms_sync.sv]
// Purpose: Two-stage synchroniser for pins from outside the ref_clk domain.
// Assumes: Inputs are slow compared with ref_clk.
// Notes:   Only the second stage is visible outside.
`timescale 1ns/1ps
module tms_sync #(
  parameter int unsigned WIDTH = 2
)(
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;

  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge ref_clk or posedge rst)
    begin
      if (rst)
      begin
        meta_r[i]   <= 1'b0;
        sync_out[i] <= 1'b0;
      end
      else
      begin
        meta_r[i]   <= async_in[i];
        sync_out[i] <= meta_r[i];
      end
    end
  end

endmodule : tms_sync

// [test/tms_host_model.sv]
// Purpose: Host controller model that drives the chip-select and SCK pins.
// Assumes: Pins are unrelated in phase to ref_clk; SCK period is 400 ns.
// Notes:   SCK stands low outside frames.
`timescale 1ns/1ps
module tms_host_model (
  output logic chip_sel,
  output logic sck
);
  initial
  begin
    chip_sel = 1'b0;
    sck      = 1'b0;
  end

  // The odd delay keeps pin edges away from the ref_clk edges.
  task automatic set_cs(input logic level);
    #37 chip_sel = level;
  endtask : set_cs

  // The host clocks SCK n times to wake the device; chip-select stays as set_cs left it.
  task automatic pulse_sck(input int n);
    repeat (n)
    begin
      #200 sck = 1'b1;
      #200 sck = 1'b0;
    end
  endtask : pulse_sck
endmodule : tms_host_model

// [test/tms_mode_sequencer_tb_top.sv]
// Purpose: Self-checking bench of the transmitter mode sequencer.
// Assumes: Pins come from the host model; bank and strobes from the bench.
// Notes:   The idle timeout is shortened to 20 cycles.
`timescale 1ns/1ps
module tms_mode_sequencer_tb_top;
  import tms_pkg::*;
  logic         ref_clk;
  logic         rst;
  wire          chip_sel;
  wire          sck;
  logic         cfg_wr_en;
  logic [4:0]   cfg_wr_addr;
  logic [7:0]   cfg_wr_data;
  logic [255:0] cfg_bank;
  logic         tx_cmd;
  logic         tx_hold;
  logic         parity_error_clr;
  tms_state_t   mode_state;
  logic         sleep_request;
  logic         retention_request;
  logic         parity_error;
  wire  [11:0]  pwr;
  wire          lp_regulator_en, normal_regulator_en, por_en;
  wire          undervoltage_full_en, undervoltage_low_en;
  wire          crystal_oscillator_en, clock_divider_en, pll_en;
  wire          power_amplifier_en, serial_if_en, core_supply_en, sys_ctrl_en;
  int           error_cnt;
  int           check_count;

  tms_host_model i_tms_host_model (.chip_sel(chip_sel), .sck(sck));

  tms_mode_sequencer #(.IDLE_TIMEOUT(20), .NUM_REGS(32)) i_tms_mode_sequencer (
    .ref_clk(ref_clk), .rst(rst), .chip_sel(chip_sel), .sck(sck),
    .cfg_wr_en(cfg_wr_en), .cfg_wr_addr(cfg_wr_addr),
    .cfg_wr_data(cfg_wr_data), .cfg_bank(cfg_bank), .tx_cmd(tx_cmd),
    .tx_hold(tx_hold), .parity_error_clr(parity_error_clr),
    .mode_state(mode_state), .sleep_request(sleep_request),
    .retention_request(retention_request), .parity_error(parity_error),
    .lp_regulator_en(lp_regulator_en),
    .normal_regulator_en(normal_regulator_en), .por_en(por_en),
    .undervoltage_full_en(undervoltage_full_en),
    .undervoltage_low_en(undervoltage_low_en),
    .crystal_oscillator_en(crystal_oscillator_en),
    .clock_divider_en(clock_divider_en), .pll_en(pll_en),
    .power_amplifier_en(power_amplifier_en), .serial_if_en(serial_if_en),
    .core_supply_en(core_supply_en), .sys_ctrl_en(sys_ctrl_en));

  // Enables gathered in the bit order of the package power patterns.
  assign pwr = {sys_ctrl_en, core_supply_en, serial_if_en, power_amplifier_en,
                pll_en, clock_divider_en, crystal_oscillator_en,
                undervoltage_low_en, undervoltage_full_en, por_en,
                normal_regulator_en, lp_regulator_en};

  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  task automatic check(input logic [11:0] seen, input logic [11:0] exp,
                       input string msg);
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg,
               seen, exp);
    end
  endtask : check

  task automatic wait_state(input tms_state_t st, input int bound);
    for (int i = 0; i < bound && mode_state !== st; i++)
      tick(1);
    check({9'h0, mode_state}, {9'h0, st}, "state wait");
    if (mode_state !== st)
      print_verdict();
  endtask : wait_state

  task automatic cfg_write(input logic [4:0] addr, input logic [7:0] data);
    cfg_wr_en   = 1'b1;
    cfg_wr_addr = addr;
    cfg_wr_data = data;
    tick(1);
    cfg_wr_en   = 1'b0;
    tick(1);
  endtask : cfg_write

  task automatic send_tx(input logic hold);
    tx_cmd  = 1'b1;
    tx_hold = hold;
    tick(1);
    tx_cmd  = 1'b0;
  endtask : send_tx

  initial
  begin
    error_cnt = 0;
    check_count = 0;
    rst = 1'b1;
    cfg_wr_en = 1'b0;
    cfg_wr_addr = 5'h00;
    cfg_wr_data = 8'h00;
    cfg_bank = '0;
    tx_cmd = 1'b0;
    tx_hold = 1'b0;
    parity_error_clr = 1'b0;
    tick(4);
    rst = 1'b0;
    check({9'h0, mode_state}, {9'h0, TMS_OSC_WARMUP}, "reset state");
    check(pwr, PWR_WARMUP, "warm-up enables");
    check({10'h0, sleep_request, retention_request}, 12'h000, "req");
    $display("test reset done");

    wait_state(TMS_STANDBY, 40);
    check(pwr, PWR_STANDBY, "standby enables");
    $display("test idle timeout done");

    cfg_write(5'h03, 8'h01);
    tick(2);
    check({11'h0, parity_error}, 12'h001, "parity flag");
    parity_error_clr = 1'b1;
    tick(1);
    check({11'h0, parity_error}, 12'h001, "set wins");
    cfg_bank[31:24] = 8'h01;
    tick(1);
    parity_error_clr = 1'b0;
    tick(2);
    check({11'h0, parity_error}, 12'h000, "parity clear");
    cfg_bank = '0;
    cfg_write(5'h03, 8'h00);
    check({11'h0, parity_error}, 12'h001, "stale bank");
    parity_error_clr = 1'b1;
    tick(1);
    parity_error_clr = 1'b0;
    check({11'h0, parity_error}, 12'h000, "parity idle");
    $display("test parity done");

    i_tms_host_model.set_cs(1'b1);
    wait_state(TMS_OSC_WARMUP, 8);
    cfg_write(TRANSMITTER_CONFIG_0_ADDR, 8'h80);
    check({11'h0, retention_request}, 12'h001, "retention set");
    i_tms_host_model.set_cs(1'b0);
    wait_state(TMS_STANDBY, 8);
    check({11'h0, retention_request}, 12'h000, "retention clr");
    $display("test retention done");

    i_tms_host_model.set_cs(1'b1);
    wait_state(TMS_OSC_WARMUP, 8);
    cfg_write(TRANSMITTER_CONFIG_1_ADDR, 8'h80);
    check({11'h0, sleep_request}, 12'h001, "sleep set");
    i_tms_host_model.set_cs(1'b0);
    tick(4);
    check({9'h0, mode_state}, {9'h0, TMS_OSC_WARMUP}, "shutdown");
    wait_state(TMS_SLEEP, 8);
    check(pwr, PWR_SLEEP, "sleep enables");
    i_tms_host_model.set_cs(1'b1);
    i_tms_host_model.pulse_sck(2);
    tick(4);
    check({9'h0, mode_state}, {9'h0, TMS_SLEEP}, "two pulses");
    i_tms_host_model.pulse_sck(1);
    wait_state(TMS_OSC_WARMUP, 8);
    check({11'h0, sleep_request}, 12'h000, "sleep clr");
    for (int r = 0; r < 32; r++)
      cfg_write(5'(r), 8'h00);
    $display("test sleep done");

    send_tx(1'b0);
    wait_state(TMS_SYNTH_WARMUP, 3);
    check(pwr, PWR_SYNTH, "synth enables");
    wait_state(TMS_TRANSMIT, 20);
    check(pwr, PWR_TRANSMIT, "transmit enables");
    i_tms_host_model.set_cs(1'b0);
    wait_state(TMS_OSC_WARMUP, 8);
    i_tms_host_model.set_cs(1'b1);
    tick(4);
    $display("test transmit done");

    send_tx(1'b1);
    wait_state(TMS_TRANSMIT, 20);
    i_tms_host_model.set_cs(1'b0);
    tick(10);
    check({9'h0, mode_state}, {9'h0, TMS_TRANSMIT}, "hold");
    wait_state(TMS_OSC_WARMUP, 30);
    $display("test hold done");
    print_verdict();
  end
endmodule : tms_mode_sequencer_tb_top
